// file: verilog/external_bus_zone_interface.sv
// Zone chip-select bus master with strobe timing, ready, hold and AXI4-Lite registers
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the address map.
`include "ext_bus_map.svh"

//////////////////////////////////////////////////////////////////////////////
module external_bus_zone_interface
  import ext_bus_pkg::*;
#(
  parameter int ADDR_W = 19,
  parameter int DATA_W = 16
) (
  input  wire logic                mclk,
  input  wire logic                reset_n,
  // AXI4-Lite slave
  input  wire logic [11:0]         s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire ext_bus_pkg::word_t  s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [11:0]         s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output ext_bus_pkg::word_t       s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // External pins
  input  wire logic                proc_mode_select_in,
  input  wire logic                bus_hold_request_n,
  output logic                     bus_hold_grant_n,
  output logic                     bus_hold_grant_oe,
  input  wire logic                access_ready_in,
  output logic [ADDR_W-1:0]        ext_address_bus,
  input  wire logic [DATA_W-1:0]   ext_data_bus_in,
  output logic [DATA_W-1:0]        ext_data_bus_out,
  output logic                     ext_data_bus_oe,
  output logic                     ctrl_bus_oe,
  output logic                     zone01_select_n,
  output logic                     zone_two_select_n,
  output logic                     zone67_select_n,
  output logic                     write_strobe_n,
  output logic                     read_strobe_n,
  output logic                     read_not_write,
  output logic                     ext_clock_output
);

  typedef enum logic [2:0] {
    S_IDLE,
    S_LEAD,
    S_ACTIVE,
    S_TRAIL,
    S_HOLD
  } xfer_state_e;

  //////////////////////////////////////////////////////////////////////////
  // Input synchronisers (two flops each)
  logic [1:0] holdSync_q;
  logic [1:0] readySync_q;
  logic [1:0] modeSync_q;
  logic [DATA_W-1:0] dataMeta_q;
  logic [DATA_W-1:0] dataSync_q;
  logic       readyRaw_q;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      holdSync_q  <= 2'b11;
      readySync_q <= 2'b00;
      modeSync_q  <= 2'b00;
      dataMeta_q  <= '0;
      dataSync_q  <= '0;
      readyRaw_q  <= 1'b0;
    end else begin
      holdSync_q  <= {holdSync_q[0], bus_hold_request_n};
      readySync_q <= {readySync_q[0], access_ready_in};
      modeSync_q  <= {modeSync_q[0], proc_mode_select_in};
      dataMeta_q  <= ext_data_bus_in;
      dataSync_q  <= dataMeta_q;
      readyRaw_q  <= readySync_q[1];
    end
  end

  // Async mode sees ready one flop later, adding a settling stage
  logic readyOk;
  logic holdReq;

  //////////////////////////////////////////////////////////////////////////
  // Registers
  word_t cfg_q, cfg_d;
  word_t tim01_q, tim01_d, tim2_q, tim2_d, tim67_q, tim67_d;
  logic [ADDR_W-1:0] xAddr_q, xAddr_d;
  logic [DATA_W-1:0] xData_q, xData_d;
  logic [2:0] xZone_q, xZone_d;
  logic       xWrite_q, xWrite_d;
  logic       pend_q, pend_d;
  logic       zoneErr_q, zoneErr_d;
  logic [1:0] modeCatch_q, modeCatch_d;
  logic       grant_q, grant_d;
  logic       awHave_q, awHave_d, wHave_q, wHave_d;
  logic [11:0] awAddr_q, awAddr_d;
  word_t      wData_q, wData_d;
  logic       bValid_q, bValid_d;
  logic [1:0] bResp_q, bResp_d;
  logic       rValid_q, rValid_d;
  logic [1:0] rResp_q, rResp_d;
  word_t      rData_q, rData_d;
  logic       accessDone;

  function automatic word_t merge_word(input word_t oldV, input word_t newV,
                                       input logic [3:0] strb);
    word_t res;
    res = oldV;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = newV[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Zone is external when its select line exists; zone 7 only while zone 7 is enabled
  function automatic logic zone_mapped(input logic [2:0] z, input logic z7en);
    return (z == `ZONE_0) || (z == `ZONE_1) || (z == `ZONE_2) ||
           (z == `ZONE_6) || ((z == `ZONE_7) && z7en);
  endfunction

  // Register file and AXI4-Lite handshake
  always_comb begin
    cfg_d = cfg_q;
    tim01_d = tim01_q;
    tim2_d = tim2_q;
    tim67_d = tim67_q;
    xAddr_d = xAddr_q;
    xData_d = xData_q;
    xZone_d = xZone_q;
    xWrite_d = xWrite_q;
    pend_d = pend_q;
    zoneErr_d = zoneErr_q;
    modeCatch_d = (modeCatch_q != 2'h0) ? modeCatch_q - 2'h1 : 2'h0;
    awHave_d = awHave_q;
    wHave_d = wHave_q;
    awAddr_d = awAddr_q;
    wData_d = wData_q;
    bValid_d = bValid_q;
    bResp_d = bResp_q;
    rValid_d = rValid_q;
    rResp_d = rResp_q;
    rData_d = rData_q;
    // Earlier catch would take the synchroniser's reset value, not the pin
    if (modeCatch_q == `MODE_CATCH_NOW) begin
      cfg_d[`CFG_ZONE7_EN_BIT] = modeSync_q[1];
    end
    if (accessDone) begin
      pend_d = 1'b0;
      if (!xWrite_q) begin
        xData_d = dataSync_q;
      end
    end
    if (s_axi_awvalid && !awHave_q) begin
      awHave_d = 1'b1;
      awAddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && !wHave_q) begin
      wHave_d = 1'b1;
      wData_d = s_axi_wdata;
    end
    if (s_axi_bready && bValid_q) begin
      bValid_d = 1'b0;
    end
    if (awHave_q && wHave_q && !bValid_q) begin
      awHave_d = 1'b0;
      wHave_d = 1'b0;
      bValid_d = 1'b1;
      bResp_d = `RESP_OKAY;
      unique case (awAddr_q)
        `REG_CONFIG_TWO: cfg_d = merge_word(cfg_q, wData_q, s_axi_wstrb);
        `REG_TIMING_Z01: tim01_d = merge_word(tim01_q, wData_q, s_axi_wstrb);
        `REG_TIMING_Z2:  tim2_d = merge_word(tim2_q, wData_q, s_axi_wstrb);
        `REG_TIMING_Z67: tim67_d = merge_word(tim67_q, wData_q, s_axi_wstrb);
        `REG_XFER_ADDR:  xAddr_d = wData_q[ADDR_W-1:0];
        `REG_XFER_DATA:  xData_d = wData_q[DATA_W-1:0];
        `REG_XFER_CTRL: begin
          if (wData_q[`CTRL_GO_BIT] && !pend_q) begin
            xZone_d = wData_q[`CTRL_ZONE_HI:`CTRL_ZONE_LO];
            xWrite_d = wData_q[`CTRL_WRITE_BIT];
            if (zone_mapped(wData_q[`CTRL_ZONE_HI:`CTRL_ZONE_LO],
                            cfg_q[`CFG_ZONE7_EN_BIT])) begin
              pend_d = 1'b1;
              zoneErr_d = 1'b0;
            end else begin
              zoneErr_d = 1'b1;
            end
          end
        end
        default: bResp_d = `RESP_SLVERR;
      endcase
    end
    if (rValid_q && s_axi_rready) begin
      rValid_d = 1'b0;
    end else if (s_axi_arvalid && !rValid_q) begin
      rValid_d = 1'b1;
      rResp_d = `RESP_OKAY;
      unique case (s_axi_araddr)
        `REG_CONFIG_TWO: rData_d = cfg_q;
        `REG_TIMING_Z01: rData_d = tim01_q;
        `REG_TIMING_Z2:  rData_d = tim2_q;
        `REG_TIMING_Z67: rData_d = tim67_q;
        `REG_STATUS:     rData_d = {28'h000_0000, zoneErr_q, ~holdSync_q[1],
                                    ~grant_q, pend_q};
        `REG_XFER_ADDR:  rData_d = {{(32-ADDR_W){1'b0}}, xAddr_q};
        `REG_XFER_DATA:  rData_d = {{(32-DATA_W){1'b0}}, xData_q};
        `REG_XFER_CTRL:  rData_d = {25'h000_0000, xZone_q, 2'h0, xWrite_q, pend_q};
        default: begin
          rData_d = 32'h0000_0000;
          rResp_d = `RESP_SLVERR;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // External access sequencer
  xfer_state_e st_q, st_d;
  logic [7:0] cnt_q, cnt_d;
  word_t tim;

  always_comb begin
    unique case (xZone_q)
      `ZONE_2: tim = tim2_q;
      `ZONE_6, `ZONE_7: tim = tim67_q;
      default: tim = tim01_q;
    endcase
  end

  assign holdReq = ~holdSync_q[1];
  assign readyOk = !tim[`TIM_USE_READY] ||
                   (cfg_q[`CFG_READY_ASYNC] ? readyRaw_q : readySync_q[1]);
  assign accessDone = (st_q == S_TRAIL) && (cnt_q == 8'h00);

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    grant_d = grant_q;
    unique case (st_q)
      S_IDLE: begin
        if (pend_q) begin                     // queued access goes out before a grant
          st_d = S_LEAD;
          cnt_d = {4'h0, tim[`TIM_LEAD_HI:`TIM_LEAD_LO]};
        end else if (holdReq) begin
          st_d = S_HOLD;
          grant_d = 1'b1;
        end
      end
      S_LEAD: begin
        if (cnt_q == 8'h00) begin
          st_d = S_ACTIVE;
          cnt_d = tim[`TIM_ACT_HI:`TIM_ACT_LO];
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end
      S_ACTIVE: begin
        if (cnt_q != 8'h00) begin
          cnt_d = cnt_q - 8'h01;
        end else if (readyOk) begin
          st_d = S_TRAIL;
          cnt_d = {4'h0, tim[`TIM_TRAIL_HI:`TIM_TRAIL_LO]};
        end
      end
      S_TRAIL: begin
        if (cnt_q == 8'h00) begin
          st_d = S_IDLE;                      // access completes before hold
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end
      S_HOLD: begin
        if (!holdReq) begin
          st_d = S_IDLE;
          grant_d = 1'b0;
        end
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Registered pin drivers
  logic sel01_q, sel2_q, sel67_q, wr_q, rd_q, rnw_q, dOe_q, cOe_q;
  logic [ADDR_W-1:0] aOut_q;
  logic inAccess_d;
  assign inAccess_d = (st_d == S_LEAD) || (st_d == S_ACTIVE) || (st_d == S_TRAIL);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= S_IDLE;
      cnt_q <= 8'h00;
      grant_q <= 1'b0;
      cfg_q <= `CFG_RESET_VAL;
      tim01_q <= `TIM_RESET_VAL;
      tim2_q <= `TIM_RESET_VAL;
      tim67_q <= `TIM_RESET_VAL;
      xAddr_q <= '0;
      xData_q <= '0;
      xZone_q <= `ZONE_0;
      xWrite_q <= 1'b0;
      pend_q <= 1'b0;
      zoneErr_q <= 1'b0;
      modeCatch_q <= `MODE_CATCH_WAIT;        // Catch strap once after release
      awHave_q <= 1'b0;
      wHave_q <= 1'b0;
      awAddr_q <= 12'h000;
      wData_q <= 32'h0000_0000;
      bValid_q <= 1'b0;
      bResp_q <= `RESP_OKAY;
      rValid_q <= 1'b0;
      rResp_q <= `RESP_OKAY;
      rData_q <= 32'h0000_0000;
      sel01_q <= 1'b1;
      sel2_q <= 1'b1;
      sel67_q <= 1'b1;
      wr_q <= 1'b1;
      rd_q <= 1'b1;
      rnw_q <= 1'b1;
      dOe_q <= 1'b0;
      cOe_q <= 1'b1;
      aOut_q <= '0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      grant_q <= grant_d;
      cfg_q <= cfg_d;
      tim01_q <= tim01_d;
      tim2_q <= tim2_d;
      tim67_q <= tim67_d;
      xAddr_q <= xAddr_d;
      xData_q <= xData_d;
      xZone_q <= xZone_d;
      xWrite_q <= xWrite_d;
      pend_q <= pend_d;
      zoneErr_q <= zoneErr_d;
      modeCatch_q <= modeCatch_d;
      awHave_q <= awHave_d;
      wHave_q <= wHave_d;
      awAddr_q <= awAddr_d;
      wData_q <= wData_d;
      bValid_q <= bValid_d;
      bResp_q <= bResp_d;
      rValid_q <= rValid_d;
      rResp_q <= rResp_d;
      rData_q <= rData_d;
      // Selects and strobes high when idle
      sel01_q <= !(inAccess_d && (xZone_q == `ZONE_0 || xZone_q == `ZONE_1));
      sel2_q <= !(inAccess_d && xZone_q == `ZONE_2);
      sel67_q <= !(inAccess_d && (xZone_q == `ZONE_6 || xZone_q == `ZONE_7));
      wr_q <= !((st_d == S_ACTIVE) && xWrite_q);
      rd_q <= !((st_d == S_ACTIVE) && !xWrite_q);
      rnw_q <= !(inAccess_d && xWrite_q);
      dOe_q <= inAccess_d && xWrite_q && !grant_d;
      cOe_q <= !grant_d;                           // float while granted
      aOut_q <= xAddr_q;
    end
  end

  ext_clock_divider u_clkdiv (
    .mclk    (mclk),
    .reset_n (reset_n),
    .mode    (clk_mode_e'(cfg_q[`CFG_CLKMODE_HI:`CFG_CLKMODE_LO])),
    .clkOff  (cfg_q[`CFG_CLKOFF_BIT]),
    .clkOut  (ext_clock_output)
  );

  assign s_axi_awready = !awHave_q;
  assign s_axi_wready = !wHave_q;
  assign s_axi_bvalid = bValid_q;
  assign s_axi_bresp = bResp_q;
  assign s_axi_arready = !rValid_q;
  assign s_axi_rvalid = rValid_q;
  assign s_axi_rresp = rResp_q;
  assign s_axi_rdata = rData_q;
  assign bus_hold_grant_n = !grant_q;
  assign bus_hold_grant_oe = 1'b1;
  assign ext_address_bus = aOut_q;
  assign ext_data_bus_out = xData_q;
  assign ext_data_bus_oe = dOe_q;
  assign ctrl_bus_oe = cOe_q;
  assign zone01_select_n = sel01_q;
  assign zone_two_select_n = sel2_q;
  assign zone67_select_n = sel67_q;
  assign write_strobe_n = wr_q;
  assign read_strobe_n = rd_q;
  assign read_not_write = rnw_q;
endmodule

// file: verilog/ext_bus_map.svh
// Register offsets, fields, reset values and timing counts of the zone bus interface
`ifndef EXT_BUS_MAP_SVH
`define EXT_BUS_MAP_SVH
// Register byte addresses
`define REG_CONFIG_TWO   12'h000
`define REG_TIMING_Z01   12'h004
`define REG_TIMING_Z2    12'h008
`define REG_TIMING_Z67   12'h00C
`define REG_STATUS       12'h010
`define REG_XFER_ADDR    12'h014
`define REG_XFER_DATA    12'h018
`define REG_XFER_CTRL    12'h01C
// Config two fields
`define CFG_ZONE7_EN_BIT 0
`define CFG_READY_ASYNC  1
`define CFG_CLKMODE_LO   4
`define CFG_CLKMODE_HI   5
`define CFG_CLKOFF_BIT   3
`define CFG_RESET_VAL    32'h0000_0020
// Strap catch countdown: catch once the two-flop synchroniser holds the pin
`define MODE_CATCH_WAIT  2'h3
`define MODE_CATCH_NOW   2'h1
// Timing fields: lead [3:0], active [11:4], trail [15:12], use ready [16]
`define TIM_LEAD_LO      0
`define TIM_LEAD_HI      3
`define TIM_ACT_LO       4
`define TIM_ACT_HI       11
`define TIM_TRAIL_LO     12
`define TIM_TRAIL_HI     15
`define TIM_USE_READY    16
`define TIM_RESET_VAL    32'h0000_3FF3
// Transfer control fields
`define CTRL_GO_BIT      0
`define CTRL_WRITE_BIT   1
`define CTRL_ZONE_LO     4
`define CTRL_ZONE_HI     6
// Zone numbers
`define ZONE_0           3'h0
`define ZONE_1           3'h1
`define ZONE_2           3'h2
`define ZONE_6           3'h6
`define ZONE_7           3'h7
// AXI responses
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2
`endif

// file: verilog/ext_bus_pkg.sv
// Types shared by the zone bus interface
package ext_bus_pkg;
  typedef enum logic [1:0] {
    CLK_FULL,
    CLK_HALF,
    CLK_QUARTER,
    CLK_QUARTER_B
  } clk_mode_e;
  typedef logic [31:0] word_t;
endpackage

// file: verilog/ext_clock_divider.sv
// Output clock divider for external wait-state logic
module ext_clock_divider
  import ext_bus_pkg::*;
(
  input  wire logic             mclk,
  input  wire logic             reset_n,
  input  wire ext_bus_pkg::clk_mode_e mode,
  input  wire logic             clkOff,
  output logic                  clkOut
);
  logic [1:0] divCnt_q;
  logic [1:0] divCnt_d;
  logic       clkOut_q;
  logic       clkOut_d;

  // Full rate is approximated by toggling a registered level on every mclk rising edge
  always_comb begin
    divCnt_d = divCnt_q + 2'h1;
    unique case (mode)
      CLK_FULL:    clkOut_d = ~clkOut_q;
      CLK_HALF:    clkOut_d = divCnt_q[0];
      default:     clkOut_d = divCnt_q[1];
    endcase
    if (clkOff) begin
      clkOut_d = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      divCnt_q <= 2'h0;
      clkOut_q <= 1'b0;
    end else begin
      divCnt_q <= divCnt_d;
      clkOut_q <= clkOut_d;
    end
  end

  assign clkOut = clkOut_q;
endmodule

// file: test/external_bus_zone_interface_assertions.sv
// Pin checker for zone selects, strobes and the hold handshake
module ext_bus_zone_checker (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic bus_hold_request_n,
  input wire logic bus_hold_grant_n,
  input wire logic ext_data_bus_oe,
  input wire logic ctrl_bus_oe,
  input wire logic zone01_select_n,
  input wire logic zone_two_select_n,
  input wire logic zone67_select_n,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic read_not_write
);
  // No select low means no access under way
  wire idle = zone01_select_n & zone_two_select_n & zone67_select_n;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////
  property p_excl; !(!write_strobe_n && !read_strobe_n); endproperty
  a_excl: assert property (p_excl) else $error("strobes overlap");
  property p_idle; idle |-> write_strobe_n && read_strobe_n; endproperty
  a_idle: assert property (p_idle) else $error("strobe without select");
  property p_rnw_wr; !write_strobe_n |-> !read_not_write; endproperty
  a_rnw_wr: assert property (p_rnw_wr) else $error("rnw high on write");
  property p_rnw_rd; !read_strobe_n |-> read_not_write; endproperty
  a_rnw_rd: assert property (p_rnw_rd) else $error("rnw low on read");
  property p_zone; $onehot0({~zone01_select_n, ~zone_two_select_n, ~zone67_select_n}); endproperty
  a_zone: assert property (p_zone) else $error("two selects low");
  property p_float; !bus_hold_grant_n |-> !ctrl_bus_oe && !ext_data_bus_oe; endproperty
  a_float: assert property (p_float) else $error("driving while granted");
  property p_nostart; $fell(idle) |-> bus_hold_grant_n && ctrl_bus_oe; endproperty
  a_nostart: assert property (p_nostart) else $error("access during hold");
  property p_finish; $fell(bus_hold_grant_n) |-> idle && $past(idle); endproperty
  a_finish: assert property (p_finish) else $error("grant mid-access");
  property p_release; bus_hold_request_n [*4] |=> bus_hold_grant_n; endproperty
  a_release: assert property (p_release) else $error("grant kept");
  property p_grant;
    $fell(bus_hold_request_n) |-> ##[1:400] (!bus_hold_grant_n || bus_hold_request_n);
  endproperty
  a_grant: assert property (p_grant) else $error("grant never given");
  // Main scenarios reached
  c_grant: cover property (!bus_hold_grant_n);
  c_write: cover property (!write_strobe_n);
  c_read: cover property (!read_strobe_n);
endmodule

bind external_bus_zone_interface ext_bus_zone_checker chk (.mclk, .reset_n,
  .bus_hold_request_n, .bus_hold_grant_n, .ext_data_bus_oe, .ctrl_bus_oe, .zone01_select_n,
  .zone_two_select_n, .zone67_select_n, .write_strobe_n, .read_strobe_n, .read_not_write);

// file: test/ext_peripheral_model.sv
// Peripheral on the zone bus: late ready, read pattern, write capture
module ext_peripheral_model (
  input  wire logic        linkClk,
  input  wire logic        selN,
  input  wire logic        wrN,
  input  wire logic        devOe,
  input  wire logic [18:0] addr,
  input  wire logic [15:0] devData,
  input  wire logic [3:0]  delay,
  output logic             ready,
  output logic [15:0]      dataIn,
  output logic [15:0]      wrSeen
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] waitQ;
  // Own clock, so ready has no phase relation to the device
  always @(posedge linkClk or posedge selN) begin
    if (selN)
      waitQ <= 4'h0;
    else if (waitQ != delay)
      waitQ <= waitQ + 4'h1;
  end
  // Ready held off until the wait runs out
  assign ready = selN | (waitQ == delay);
  // Wire level: device, else peripheral while selected, else pull-up
  assign dataIn = devOe ? devData : (!selN ? {4'hA, addr[11:0]} : 16'hFFFF);
  // Write data taken as the strobe rises
  always @(posedge wrN) wrSeen <= dataIn;
endmodule

// file: test/external_bus_zone_interface_test.sv
// Self-checking bench of the zone bus interface
`include "ext_bus_map.svh"
module external_bus_zone_interface_test;
  timeunit 1ns;
  timeprecision 1ps;
  import ext_bus_pkg::*;
  logic        mclk = 1'h0, linkClk = 1'h0, reset_n = 1'h0, clkPrev = 1'h0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  word_t       s_axi_wdata = 32'h0000_0000, s_axi_rdata, d;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, proc_mode_select_in = 1'h1;
  logic        bus_hold_request_n = 1'h1, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, bus_hold_grant_n, ext_data_bus_oe, ctrl_bus_oe;
  logic        zone01_select_n, zone_two_select_n, zone67_select_n, write_strobe_n;
  logic        read_strobe_n, read_not_write, ext_clock_output, access_ready_in, grantOe;
  logic [1:0]  s_axi_bresp, s_axi_rresp, lastResp;
  logic [18:0] ext_address_bus, a;
  logic [15:0] ext_data_bus_in, ext_data_bus_out, wrSeen;
  logic [3:0]  delay = 4'h0;
  int          cnt [7], miscompares = 0, cmpCount = 0;
  wire         idle = zone01_select_n & zone_two_select_n & zone67_select_n;
  // Ordinary cases: zone, direction, select index; expected lengths per select
  logic [2:0]  rowZone [6] = '{3'h0, 3'h1, 3'h2, 3'h2, 3'h6, 3'h7};
  logic        rowWr [6] = '{1'h1, 1'h0, 1'h1, 1'h0, 1'h0, 1'h1};
  int          rowSel [6] = '{0, 0, 1, 1, 2, 2};
  int          selExp [3] = '{7, 8, 6};
  int          strExp [3] = '{3, 4, 2};
  // Device clock and an unrelated peripheral clock
  always #4 mclk = ~mclk;
  always #62.5 linkClk = ~linkClk;
  external_bus_zone_interface uut (.mclk, .reset_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .proc_mode_select_in, .bus_hold_request_n, .bus_hold_grant_n, .bus_hold_grant_oe(grantOe),
    .access_ready_in, .ext_address_bus, .ext_data_bus_in, .ext_data_bus_out,
    .ext_data_bus_oe, .ctrl_bus_oe, .zone01_select_n, .zone_two_select_n,
    .zone67_select_n, .write_strobe_n, .read_strobe_n, .read_not_write, .ext_clock_output);
  ext_peripheral_model peer (.linkClk(linkClk), .selN(idle), .wrN(write_strobe_n),
    .devOe(ext_data_bus_oe), .addr(ext_address_bus), .devData(ext_data_bus_out),
    .delay(delay), .ready(access_ready_in), .dataIn(ext_data_bus_in), .wrSeen(wrSeen));
  ////////////////////////////////////////
  // Pin activity: selects, strobes, rnw low, output clock rises
  always @(posedge mclk) begin
    cnt[0] += int'(zone01_select_n === 1'h0);
    cnt[1] += int'(zone_two_select_n === 1'h0);
    cnt[2] += int'(zone67_select_n === 1'h0);
    cnt[3] += int'(write_strobe_n === 1'h0);
    cnt[4] += int'(read_strobe_n === 1'h0);
    cnt[5] += int'(read_not_write === 1'h0);
    cnt[6] += int'(ext_clock_output === 1'h1 && clkPrev === 1'h0);
    clkPrev = ext_clock_output;
  end
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", cmpCount, miscompares);
    if (miscompares == 0 && cmpCount > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Write: address and data offered together, each dropped when taken
  task automatic axiWrite(input logic [11:0] ad, input word_t wd);
    @(posedge mclk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= wd;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge mclk);
      if (s_axi_awvalid && s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    lastResp = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task automatic axiRead(input logic [11:0] ad, output word_t rd);
    @(posedge mclk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge mclk);
      if (s_axi_arvalid && s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    rd = s_axi_rdata;
    lastResp = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  // Waits for a select to fall and rise again; gives up quietly if none
  task automatic waitDone();
    bit seen = 1'b0;
    for (int n = 0; n < 400; n++) begin
      @(posedge mclk);
      if (idle === 1'h0) seen = 1'b1;
      else if (seen) break;
    end
  endtask
  // Counters cleared off the sampling edge to avoid a race
  task automatic runAccess(input logic [2:0] z, input logic wr);
    @(negedge mclk);
    cnt = '{default: 0};
    axiWrite(`REG_XFER_CTRL, {25'h000_0000, z, 2'h0, wr, 1'h1});
    waitDone();
  endtask
  task automatic clockRises(input int n);
    repeat (8) @(negedge mclk);
    cnt[6] = 0;
    repeat (32) @(negedge mclk);
    check(cnt[6], n);
  endtask
  // Watchdog far beyond the expected run
  initial begin
    #200_000;
    miscompares++;
    final_report();
  end
  initial begin
    repeat (4) @(posedge mclk);
    reset_n <= 1'h1;
    repeat (3) @(posedge mclk);
    axiRead(`REG_CONFIG_TWO, d);
    check(d, 32'h0000_0021);
    check(grantOe, 1'h1);
    axiRead(`REG_TIMING_Z2, d);
    check(d, `TIM_RESET_VAL);
    axiRead(12'h020, d);
    check(lastResp, `RESP_SLVERR);
    proc_mode_select_in <= 1'h0;
    clockRises(8);
    axiWrite(`REG_TIMING_Z01, 32'h0000_1021);
    axiWrite(`REG_TIMING_Z2, 32'h0000_0032);
    axiWrite(`REG_TIMING_Z67, 32'h0000_2010);
    for (int i = 0; i < 6; i++) begin
      a = 19'h1_0000 | 19'(i << 8);
      axiWrite(`REG_XFER_ADDR, 32'(a));
      axiWrite(`REG_XFER_DATA, 32'h0000_5A00 + i);
      runAccess(rowZone[i], rowWr[i]);
      for (int k = 0; k < 3; k++) check(cnt[k], k == rowSel[i] ? selExp[k] : 0);
      check(cnt[3], rowWr[i] ? strExp[rowSel[i]] : 0);
      check(cnt[4], rowWr[i] ? 0 : strExp[rowSel[i]]);
      check(cnt[5], rowWr[i] ? selExp[rowSel[i]] : 0);
      check(ext_address_bus, a);
      axiRead(`REG_XFER_DATA, d);
      check(rowWr[i] ? wrSeen : d[15:0], rowWr[i] ? 16'h5A00 + i : {4'hA, a[11:0]});
    end
    axiWrite(`REG_CONFIG_TWO, 32'h0000_0011);
    clockRises(16);
    // Full-rate setting toggles every rising edge; clock off holds the pin low
    axiWrite(`REG_CONFIG_TWO, 32'h0000_0001);
    clockRises(16);
    axiWrite(`REG_CONFIG_TWO, 32'h0000_0029);
    clockRises(0);
    // Late ready in both sampling modes, hold asked mid-access
    delay <= 4'h3;
    axiWrite(`REG_TIMING_Z2, 32'h0001_0032);
    for (int m = 0; m < 2; m++) begin
      axiWrite(`REG_CONFIG_TWO, 32'h0000_0021 | (m << 1));
      @(negedge mclk);
      cnt = '{default: 0};
      axiWrite(`REG_XFER_CTRL, 32'h0000_0021);
      while (read_strobe_n !== 1'h0) @(posedge mclk);
      bus_hold_request_n <= 1'h0;
      waitDone();
      check(cnt[4] > 25, 1);
      check(cnt[1], cnt[4] + 4);
      while (bus_hold_grant_n !== 1'h0) @(posedge mclk);
      check(ctrl_bus_oe, 1'h0);
      bus_hold_request_n <= 1'h1;
      while (bus_hold_grant_n !== 1'h1) @(posedge mclk);
    end
    // Access asked while the bus is granted away; no select falls until the release
    bus_hold_request_n <= 1'h0;
    while (bus_hold_grant_n !== 1'h0) @(posedge mclk);
    runAccess(3'h0, 1'h0);
    check(cnt[0], 0);
    bus_hold_request_n <= 1'h1;
    waitDone();
    check(cnt[0], 7);
    axiWrite(`REG_CONFIG_TWO, 32'h0000_0020);
    runAccess(3'h7, 1'h1);
    check(cnt[2], 0);
    axiRead(`REG_STATUS, d);
    check(d[3], 1'h1);
    // Second reset with the strap low
    reset_n <= 1'h0;
    repeat (4) @(posedge mclk);
    reset_n <= 1'h1;
    repeat (3) @(posedge mclk);
    axiRead(`REG_CONFIG_TWO, d);
    check(d, 32'h0000_0020);
    final_report();
  end
endmodule
